// [shared/adc_seq_pkg.sv]
/*
  Shared constants and types for the converter sequencer: register
  offsets, field positions, reset values, trigger codes and carriers.
  Assumes a plain register port with byte addresses of 8 bits.
*/
package adc_seq_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFS_CONTROL_THREE = 8'h08;
  localparam logic [7:0] OFS_CHANNEL_SELECT = 8'h0c;
  localparam logic [7:0] OFS_SCAN_INPUT = 8'h10;
  localparam logic [7:0] OFS_RESULT_BASE = 8'h40;

  // ==========================================================
  // Field positions
  localparam int TRIG_SRC_HI = 7;
  localparam int TRIG_SRC_LO = 5;
  localparam int EDGE_RISE_BIT = 4;
  localparam int AUTO_SAMPLE_BIT = 2;
  localparam int SAMPLE_HOLD_BIT = 1;
  localparam int CONV_DONE_BIT = 0;
  localparam int REF_SEL_HI = 15;
  localparam int REF_SEL_LO = 13;
  localparam int SCAN_EN_BIT = 10;
  localparam int HALF_STATUS_BIT = 7;
  localparam int PER_IRQ_HI = 5;
  localparam int PER_IRQ_LO = 2;
  localparam int DUAL_BUF_BIT = 1;
  localparam int ALT_MUX_BIT = 0;
  localparam int AUTO_TIME_HI = 12;
  localparam int AUTO_TIME_LO = 8;
  localparam int A_POS_HI = 19;
  localparam int A_POS_LO = 16;
  localparam int A_NEG_BIT = 23;
  localparam int B_POS_HI = 27;
  localparam int B_POS_LO = 24;
  localparam int B_NEG_BIT = 31;

  // ==========================================================
  // Sizes, codes and counts
  localparam int SLOT_COUNT = 16;
  localparam logic [3:0] HALF_LAST_IDX = 4'h7;
  localparam logic [4:0] AUTO_TIME_MIN = 5'h01;
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_PIN = 3'h1;
  localparam logic [2:0] TRIG_TIMER = 3'h2;
  localparam logic [2:0] TRIG_AUX = 3'h3;
  localparam logic [2:0] TRIG_AUTO = 3'h7;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [3:0] pos;
    logic neg;
  } mux_sel_t;

  typedef struct packed {
    logic [2:0] trigger_source_select;
    logic edge_rise;
    logic auto_sample_enable;
    logic [2:0] reference_select;
    logic scan_enable;
    logic [3:0] samples_per_interrupt;
    logic dual_buffer_mode;
    logic alternate_mux_enable;
    logic [4:0] auto_sample_time;
    mux_sel_t mux_a;
    mux_sel_t mux_b;
    logic [15:0] scan_input_select;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '0;

endpackage

// [verilog/scan_picker.sv]
/*
  Finds the lowest selected input at or above a start index.
  Assumes a 16-bit selection mask; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module scan_picker (
  input wire logic [15:0] mask,
  input wire logic [3:0] start,
  output logic [3:0] pick,
  output logic found
);

  // ==========================================================
  // Downward loop so the lowest qualifying input wins
  always_comb begin
    pick = 4'h0;
    found = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= start)) begin
        pick = 4'(i);
        found = 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [verilog/adc_trigger_scan_sequencer.sv]
/*
  Trigger selection, sampling control, input scan and result buffer
  fill for a 10-bit successive-approximation converter.
  Assumes the analog core, timer and auxiliary trigger share clk; the
  external trigger pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Trigger source comes from control_one bits 7:5.
// - Code 000 converts when software clears the sample bit.
// - Code 010 converts on the timer period-match trigger.
// - Code 001 converts on the chosen edge of the trigger pin.
// - Code 111 converts after the auto sample time, continuously when auto sampling is on.
// - With auto sampling, each event trigger ends sampling.
// - Manual sampling starts only when software sets the bit.
// - Auto sampling restarts acquisition after each conversion.
// - Reference select in control_two bits 15:13 picks refs.
// - Scan mode takes MUX A positive from the scan mask.
// - Scan ascends and restarts at lowest input per interrupt.
// - Scanning ignores mux_a_positive_select; else it is used.
// - Extra selected scan inputs beyond the count go unsampled.
// - MUX A negative stays from its own field while scanning.
// - Scan with alternate mode interleaves the MUX B input.
// - Conversions per interrupt equal samples field plus one, at most eight in dual buffer mode.
// - Results fill consecutive slots from zero or eight.
// - A sequence never exceeds sixteen conversions.
// - Dual buffer mode fills two eight-slot halves in turn.
// - Alternate mode swaps MUX A and B, starting with A.
// - Auto mode waits auto_sample_time clocks, one when it is zero, before converting.

module adc_trigger_scan_sequencer
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire bus_req_t bus_req,
  output logic [31:0] rd_data,
  input wire logic external_trigger_pin,
  input wire logic trigger_timer,
  input wire logic aux_trigger,
  input wire logic conv_done,
  input wire logic [9:0] conv_result,
  output logic sample_en,
  output logic conv_start,
  output mux_sel_t mux_sel,
  output logic [2:0] reference_select,
  output logic sequence_done
);

  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} state_t;

  state_t state_r, state_nxt;
  ctrl_t ctrl_r, ctrl_nxt;
  mux_sel_t sel_r, sel_nxt, cur_sel;
  logic sample_hold_r, sample_hold_nxt;
  logic done_r, done_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic [3:0] scan_idx_r, scan_idx_nxt;
  logic half_r, half_nxt;
  logic alt_b_r, alt_b_nxt;
  logic conv_start_r, conv_start_nxt;
  logic seq_done_r, seq_done_nxt;
  logic [31:0] rd_data_r, rd_nxt;
  logic [9:0] result_mem [0:SLOT_COUNT-1];
  logic buf_we;
  logic [3:0] buf_addr;
  logic hw_clear, hw_set, done_set;
  logic pin_s1_r, pin_s2_r, pin_prev_r;
  logic pin_edge, trig_hit, last;
  logic [4:0] auto_sample_time_eff;
  logic [3:0] limit, scan_pick, pick0, pick_first;
  logic found0, found_first, wr_one;

  // ==========================================================
  // Trigger pin synchroniser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_s1_r <= external_trigger_pin;
      pin_s2_r <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  assign pin_edge = (pin_s2_r != pin_prev_r) &&
                    (pin_s2_r == ctrl_r.edge_rise);

  // ==========================================================
  // Scan pointer lookup
  scan_picker u_pick_next (
    .mask(ctrl_r.scan_input_select),
    .start(scan_idx_r),
    .pick(pick0),
    .found(found0)
  );

  scan_picker u_pick_first (
    .mask(ctrl_r.scan_input_select),
    .start(4'h0),
    .pick(pick_first),
    .found(found_first)
  );

  // wrap to the lowest selected input
  assign scan_pick = found0 ? pick0 : pick_first;

  // fixed field when scan is off
  // MUX B stays a single input
  always_comb begin
    cur_sel = ctrl_r.mux_a;
    if (alt_b_r) begin
      cur_sel = ctrl_r.mux_b;
    end else if (ctrl_r.scan_enable) begin
      cur_sel.pos = scan_pick;
    end
  end

  // ==========================================================
  // Trigger selection
  assign auto_sample_time_eff = (ctrl_r.auto_sample_time == 5'h00) ?
                    AUTO_TIME_MIN : ctrl_r.auto_sample_time;

  always_comb begin
    unique case (ctrl_r.trigger_source_select)
      TRIG_MANUAL: trig_hit = !sample_hold_r;
      TRIG_PIN: trig_hit = pin_edge;
      TRIG_TIMER: trig_hit = trigger_timer;
      TRIG_AUX: trig_hit = aux_trigger;
      TRIG_AUTO: trig_hit = (cnt_r + 5'h01) >= auto_sample_time_eff;
      default: trig_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Buffer sequencing
  // count is field plus one, at most eight in dual buffer mode
  // four bits cap the list at sixteen
  assign limit = (ctrl_r.dual_buffer_mode &&
                  ctrl_r.samples_per_interrupt > HALF_LAST_IDX) ?
                 HALF_LAST_IDX : ctrl_r.samples_per_interrupt;
  assign last = (idx_r == limit);
  assign wr_one = bus_req.wr && (bus_req.addr == OFS_CONTROL_ONE);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    idx_nxt = idx_r;
    scan_idx_nxt = scan_idx_r;
    half_nxt = half_r;
    alt_b_nxt = alt_b_r;
    conv_start_nxt = 1'b0;
    seq_done_nxt = 1'b0;
    buf_we = 1'b0;
    hw_clear = 1'b0;
    hw_set = 1'b0;
    done_set = 1'b0;
    sel_nxt = cur_sel;
    buf_addr = (ctrl_r.dual_buffer_mode && half_r) ?
               {1'b1, idx_r[2:0]} : idx_r;
    unique case (state_r)
      ST_IDLE: begin
        cnt_nxt = 5'h00;
        // only a set bit starts acquisition
        if (sample_hold_r) begin
          state_nxt = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        cnt_nxt = cnt_r + 5'h01;
        // auto mode ends sampling on count
        if (trig_hit) begin
          state_nxt = ST_CONVERT;
          conv_start_nxt = 1'b1;
          hw_clear = 1'b1;
        end else if (!sample_hold_r) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_CONVERT: begin
        if (conv_done) begin
          buf_we = 1'b1;
          done_set = 1'b1;
          state_nxt = ST_IDLE;
          hw_set = ctrl_r.auto_sample_enable;
          if (last) begin
            idx_nxt = 4'h0;
            scan_idx_nxt = 4'h0;
            alt_b_nxt = 1'b0;
            seq_done_nxt = 1'b1;
            half_nxt = ctrl_r.dual_buffer_mode && !half_r;
          end else begin
            idx_nxt = idx_r + 4'h1;
            alt_b_nxt = ctrl_r.alternate_mux_enable && !alt_b_r;
            if (!alt_b_r) begin
              scan_idx_nxt = scan_pick + 4'h1;
            end
          end
        end
      end
    endcase
  end

  // ==========================================================
  // Software writes; hardware set wins over software clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    sample_hold_nxt = sample_hold_r;
    done_nxt = done_r;
    if (hw_clear) begin
      sample_hold_nxt = 1'b0;
    end
    if (wr_one) begin
      ctrl_nxt.trigger_source_select =
        bus_req.wdata[TRIG_SRC_HI:TRIG_SRC_LO];
      ctrl_nxt.edge_rise = bus_req.wdata[EDGE_RISE_BIT];
      ctrl_nxt.auto_sample_enable = bus_req.wdata[AUTO_SAMPLE_BIT];
      sample_hold_nxt = bus_req.wdata[SAMPLE_HOLD_BIT];
      done_nxt = bus_req.wdata[CONV_DONE_BIT];
    end
    if (hw_set) begin
      sample_hold_nxt = 1'b1;
    end
    if (done_set) begin
      done_nxt = 1'b1;
    end
    if (bus_req.wr) begin
      case (bus_req.addr)
        OFS_CONTROL_TWO: begin
          ctrl_nxt.reference_select =
            bus_req.wdata[REF_SEL_HI:REF_SEL_LO];
          ctrl_nxt.scan_enable = bus_req.wdata[SCAN_EN_BIT];
          ctrl_nxt.samples_per_interrupt =
            bus_req.wdata[PER_IRQ_HI:PER_IRQ_LO];
          ctrl_nxt.dual_buffer_mode = bus_req.wdata[DUAL_BUF_BIT];
          ctrl_nxt.alternate_mux_enable = bus_req.wdata[ALT_MUX_BIT];
        end
        OFS_CONTROL_THREE: begin
          ctrl_nxt.auto_sample_time =
            bus_req.wdata[AUTO_TIME_HI:AUTO_TIME_LO];
        end
        OFS_CHANNEL_SELECT: begin
          ctrl_nxt.mux_a.pos = bus_req.wdata[A_POS_HI:A_POS_LO];
          ctrl_nxt.mux_a.neg = bus_req.wdata[A_NEG_BIT];
          ctrl_nxt.mux_b.pos = bus_req.wdata[B_POS_HI:B_POS_LO];
          ctrl_nxt.mux_b.neg = bus_req.wdata[B_NEG_BIT];
        end
        OFS_SCAN_INPUT: begin
          ctrl_nxt.scan_input_select = bus_req.wdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      ctrl_r <= CTRL_RESET;
      sel_r <= '0;
      sample_hold_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= 5'h00;
      idx_r <= 4'h0;
      scan_idx_r <= 4'h0;
      half_r <= 1'b0;
      alt_b_r <= 1'b0;
      conv_start_r <= 1'b0;
      seq_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      sel_r <= sel_nxt;
      sample_hold_r <= sample_hold_nxt;
      done_r <= done_nxt;
      cnt_r <= cnt_nxt;
      idx_r <= idx_nxt;
      scan_idx_r <= scan_idx_nxt;
      half_r <= half_nxt;
      alt_b_r <= alt_b_nxt;
      conv_start_r <= conv_start_nxt;
      seq_done_r <= seq_done_nxt;
    end
  end

  // Results stay until overwritten, so software must drain them
  // before the next sequence reaches the same slot
  // overwrite on each sequence
  always_ff @(posedge clk) begin
    if (buf_we) begin
      result_mem[buf_addr] <= conv_result;
    end
  end

  // ==========================================================
  // Register reads, answer one cycle later
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (bus_req.rd) begin
      case (bus_req.addr)
        OFS_CONTROL_ONE: begin
          rd_nxt[TRIG_SRC_HI:TRIG_SRC_LO] =
            ctrl_r.trigger_source_select;
          rd_nxt[EDGE_RISE_BIT] = ctrl_r.edge_rise;
          rd_nxt[AUTO_SAMPLE_BIT] = ctrl_r.auto_sample_enable;
          rd_nxt[SAMPLE_HOLD_BIT] = sample_hold_r;
          rd_nxt[CONV_DONE_BIT] = done_r;
        end
        OFS_CONTROL_TWO: begin
          rd_nxt[REF_SEL_HI:REF_SEL_LO] = ctrl_r.reference_select;
          rd_nxt[SCAN_EN_BIT] = ctrl_r.scan_enable;
          rd_nxt[HALF_STATUS_BIT] = half_r;
          rd_nxt[PER_IRQ_HI:PER_IRQ_LO] =
            ctrl_r.samples_per_interrupt;
          rd_nxt[DUAL_BUF_BIT] = ctrl_r.dual_buffer_mode;
          rd_nxt[ALT_MUX_BIT] = ctrl_r.alternate_mux_enable;
        end
        OFS_CONTROL_THREE: begin
          rd_nxt[AUTO_TIME_HI:AUTO_TIME_LO] = ctrl_r.auto_sample_time;
        end
        OFS_CHANNEL_SELECT: begin
          rd_nxt[A_POS_HI:A_POS_LO] = ctrl_r.mux_a.pos;
          rd_nxt[A_NEG_BIT] = ctrl_r.mux_a.neg;
          rd_nxt[B_POS_HI:B_POS_LO] = ctrl_r.mux_b.pos;
          rd_nxt[B_NEG_BIT] = ctrl_r.mux_b.neg;
        end
        OFS_SCAN_INPUT: begin
          rd_nxt[15:0] = ctrl_r.scan_input_select;
        end
        default: begin
          if (bus_req.addr[7:6] == OFS_RESULT_BASE[7:6] &&
              bus_req.addr[1:0] == 2'h0) begin
            rd_nxt[9:0] = result_mem[bus_req.addr[5:2]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= 32'h0000_0000;
    end else begin
      rd_data_r <= rd_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign sample_en = sample_hold_r;
  assign conv_start = conv_start_r;
  assign mux_sel = sel_r;
  assign reference_select = ctrl_r.reference_select;
  assign sequence_done = seq_done_r;

  // ==========================================================
  // Checks
  a_manual_start:
  assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_SAMPLE && !sample_hold_r &&
    ctrl_r.trigger_source_select == TRIG_MANUAL |=> conv_start)
    else $error("manual clear did not start conversion");

  a_timer_start:
  assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_SAMPLE && trigger_timer &&
    ctrl_r.trigger_source_select == TRIG_TIMER
    |=> conv_start ##1 state_r == ST_CONVERT)
    else $error("timer trigger missed");

  a_pin_start:
  assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_SAMPLE && pin_edge &&
    ctrl_r.trigger_source_select == TRIG_PIN |=> conv_start)
    else $error("pin edge did not start conversion");

  a_auto_time:
  assert property (@(posedge clk) disable iff (!rst_b)
    conv_start && ctrl_r.trigger_source_select == TRIG_AUTO &&
    $stable(ctrl_r.auto_sample_time)
    |-> $past(cnt_r) + 5'h01 == auto_sample_time_eff)
    else $error("auto sample time wrong");

  a_manual_hold:
  assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_IDLE && !sample_hold_r |=> state_r == ST_IDLE)
    else $error("acquisition started without the bit");

  a_auto_restart:
  assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_CONVERT && conv_done &&
    ctrl_r.auto_sample_enable |=> sample_hold_r ##1
    state_r == ST_SAMPLE)
    else $error("auto sampling did not restart");

  a_scan_pos:
  assert property (@(posedge clk) disable iff (!rst_b)
    ctrl_r.scan_enable && !alt_b_r && found0
    |=> mux_sel.pos == $past(pick0))
    else $error("scan input not selected");

  a_neg_kept:
  assert property (@(posedge clk) disable iff (!rst_b)
    !alt_b_r |=> mux_sel.neg == $past(ctrl_r.mux_a.neg))
    else $error("negative input changed by scan");

  a_slot_wrap:
  assert property (@(posedge clk) disable iff (!rst_b)
    state_r == ST_CONVERT && conv_done && last
    |=> sequence_done && idx_r == 4'h0 && !alt_b_r)
    else $error("sequence did not restart");

endmodule

`default_nettype wire

// [sim/sar_core_model.sv]
/*
  Behavioural model of the sample-and-hold and SAR core.
  Assumes it shares clk with the sequencer; latency >= 1 cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module sar_core_model
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic conv_start,
  input wire mux_sel_t mux_sel,
  input wire logic [7:0] latency,
  output logic conv_done,
  output logic [9:0] conv_result
);
  // ============================================================
  // Conversion timing
  logic busy_r;
  logic [7:0] cnt_r;
  logic [9:0] held_r;
  // Result encodes the sampled input so the bench can see the mux order
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      held_r <= 10'h000;
      conv_done <= 1'b0;
      conv_result <= 10'h000;
    end else begin
      conv_done <= 1'b0;
      // Bus not held between answers, so stale data never looks valid
      conv_result <= ~conv_result;
      if (conv_start) begin
        busy_r <= 1'b1;
        cnt_r <= latency;
        held_r <= {5'h00, mux_sel};
      end else if (busy_r) begin
        if (cnt_r <= 8'h01) begin
          busy_r <= 1'b0;
          conv_done <= 1'b1;
          conv_result <= held_r;
        end else begin
          cnt_r <= cnt_r - 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [sim/adc_trigger_scan_sequencer_tb_top.sv]
/*
  Self-checking bench for the sequencer: table of scan and buffer
  cases, then trigger, timing and reset tests.
  Assumes the core model in sim/ and the shared package.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_trigger_scan_sequencer_tb_top
  import adc_seq_pkg::*;
();
  // ============================================================
  // Signals and instances
  typedef struct {
    logic [31:0] c2;
    logic [15:0] mask;
    logic [31:0] chs;
    int nseq;
  } row_t;
  logic clk, rst_b, ext_pin, timer_trig, aux_trig;
  logic conv_done, sample_en, conv_start, seq_done;
  logic [31:0] rd_data;
  logic [9:0] conv_result;
  logic [2:0] ref_sel;
  logic [7:0] lat;
  mux_sel_t mux_sel;
  bus_req_t req;
  int failures, comparisons, starts;
  row_t rows [9] = '{
    '{32'h08, 16'h0000, 32'h8c850000, 2}, '{32'h40c, 16'h0124, 32'h0c030000, 1},
    '{32'h404, 16'hf0f0, 32'h8c850000, 2}, '{32'h415, 16'h0a02, 32'h8c850000, 1},
    '{32'h0a, 16'h0000, 32'h0c030000, 2}, '{32'h3e, 16'h0000, 32'h8c850000, 2},
    '{32'h438, 16'hffff, 32'h8c850000, 1}, '{32'h43d, 16'h8001, 32'h0c030000, 1},
    '{32'h05, 16'h0000, 32'h8c850000, 2}};

  adc_trigger_scan_sequencer uut (.clk(clk), .rst_b(rst_b), .bus_req(req),
    .rd_data(rd_data), .external_trigger_pin(ext_pin),
    .trigger_timer(timer_trig), .aux_trigger(aux_trig),
    .conv_done(conv_done), .conv_result(conv_result),
    .sample_en(sample_en), .conv_start(conv_start), .mux_sel(mux_sel),
    .reference_select(ref_sel), .sequence_done(seq_done));
  sar_core_model core (.clk(clk), .rst_b(rst_b), .conv_start(conv_start),
    .mux_sel(mux_sel), .latency(lat), .conv_done(conv_done),
    .conv_result(conv_result));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (conv_start === 1'b1) starts = starts + 1;

  // ============================================================
  // Tasks
  task automatic report_and_stop();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    req <= '0;
    #1 d = rd_data;
  endtask
  // Bounded wait: 0 conv_start, 1 sequence_done, 2 sample_en
  task automatic wait_ev(input int w, output int cyc);
    cyc = 0;
    do begin
      @(posedge clk);
      timer_trig <= 1'b0;
      aux_trig <= 1'b0;
      #1 cyc++;
      if (cyc > 3000) begin
        failures++;
        $display("[FAIL] wait %0d timed out", w);
        report_and_stop();
      end
    end while (!((w == 0 && conv_start === 1'b1) ||
      (w == 1 && seq_done === 1'b1) || (w == 2 && sample_en === 1'b1)));
  endtask
  task automatic idle_chk();
    starts = 0;
    repeat (8) @(posedge clk);
    #1 chk("no conversion", starts, 0);
  endtask
  // Pin toggles; timer and aux pulses drop at the next edge, so
  // arm before wait_ev counts the sampling edge as cycle one
  task automatic arm(input int t);
    if (t == 1) ext_pin <= ~ext_pin;
    if (t == 2) timer_trig <= 1'b1;
    if (t == 3) aux_trig <= 1'b1;
  endtask
  task automatic fire(input int t);
    arm(t);
    @(posedge clk);
    timer_trig <= 1'b0;
    aux_trig <= 1'b0;
    #1;
  endtask
  function automatic logic [9:0] exp_res(int k, logic [31:0] c2,
      logic [15:0] m, logic [31:0] cs);
    int cnt;
    logic [3:0] p;
    p = cs[19:16];
    if (c2[0] && k[0]) return {5'h00, cs[27:24], cs[31]};
    if (c2[10]) begin
      cnt = (c2[0] ? k / 2 : k) % $countones(m);
      for (int i = 0; i < 16; i++) if (m[i]) begin
        if (cnt == 0) p = i[3:0];
        cnt--;
      end
    end
    return {5'h00, p, cs[23]};
  endfunction

  // ============================================================
  // Main sequence
  initial begin
    int cyc, n, t4, base;
    logic [31:0] d;
    rst_b = 1'b0;
    ext_pin = 1'b0;
    timer_trig = 1'b0;
    aux_trig = 1'b0;
    req = '0;
    lat = 8'd9;
    failures = 0;
    comparisons = 0;
    starts = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    // Long sample time leaves room to read a half before overwrite
    // drain before overwrite
    foreach (rows[r]) begin
      lat = r[0] ? 8'd1 : 8'd9;
      wr(OFS_CONTROL_TWO, rows[r].c2);
      wr(OFS_SCAN_INPUT, {16'h0, rows[r].mask});
      wr(OFS_CHANNEL_SELECT, rows[r].chs);
      wr(OFS_CONTROL_THREE, 32'h1f00);
      n = rows[r].c2[5:2] + 1;
      if (rows[r].c2[1] && n > 8) n = 8;
      wr(OFS_CONTROL_ONE, 32'he6);
      for (int s = 0; s < rows[r].nseq; s++) begin
        starts = 0;
        wait_ev(1, cyc);
        chk("conversions", starts, n);
        // Stop with an inert source code: a manual clear would convert
        if (s == rows[r].nseq - 1) wr(OFS_CONTROL_ONE, 32'h80);
        base = (rows[r].c2[1] && s[0]) ? 8 : 0;
        for (int k = 0; k < n; k++) begin
          rd(OFS_RESULT_BASE + 8'(4 * (base + k)), d);
          chk("slot", d, {22'h0, exp_res(k, rows[r].c2, rows[r].mask,
            rows[r].chs)});
        end
      end
    end
    lat = 8'd1;
    wr(OFS_CONTROL_THREE, 32'h1f00);
    rd(OFS_CONTROL_THREE, d);
    chk("control_three", d, 32'h1f00);
    wr(OFS_CONTROL_TWO, 32'ha000);
    rd(OFS_CONTROL_TWO, d);
    chk("control_two", d, 32'ha000);
    chk("reference_select", ref_sel, 3'h5);
    rd(8'h20, d);
    chk("unmapped", d, 32'h0);
    wr(OFS_CONTROL_ONE, 32'h02);
    idle_chk();
    chk("manual sample_en", sample_en, 1'b1);
    wr(OFS_CONTROL_ONE, 32'h00);
    wait_ev(0, cyc);
    chk("manual delay", cyc, 1);
    repeat (10) @(posedge clk);
    #1 chk("no resample", sample_en, 1'b0);
    for (int t = 1; t < 4; t++) begin
      wr(OFS_CONTROL_ONE, 32'(t * 32 + 22));
      idle_chk();
      arm(t);
      wait_ev(0, cyc);
      chk("trigger delay", cyc, t == 1 ? 3 : 1);
      chk("sampling ended", sample_en, 1'b0);
      wait_ev(2, cyc);
      chk("auto resample", cyc < 6, 1'b1);
    end
    fire(1);
    idle_chk();
    wr(OFS_CONTROL_ONE, 32'h26);
    fire(1);
    idle_chk();
    arm(1);
    wait_ev(0, cyc);
    chk("falling edge", cyc, 3);
    for (int t = 4; t < 7; t++) begin
      wr(OFS_CONTROL_ONE, 32'(t * 32 + 6));
      fire(1);
      fire(2);
      fire(3);
      idle_chk();
    end
    wr(OFS_CONTROL_ONE, 32'h80);
    for (int a = 4; a <= 12; a += 8) begin
      wr(OFS_CONTROL_THREE, 32'(a << 8));
      wr(OFS_CONTROL_ONE, 32'he6);
      wait_ev(0, cyc);
      if (a == 4) t4 = cyc;
      wait_ev(0, n);
      wr(OFS_CONTROL_ONE, 32'h0);
      repeat (5) @(posedge clk);
      #1;
    end
    chk("sample time", cyc - t4, 8);
    wr(OFS_CONTROL_ONE, 32'h46);
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b0;
    #2 chk("reset outputs", {sample_en, conv_start, mux_sel, ref_sel}, 0);
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1 rd(OFS_CONTROL_ONE, d);
    chk("control_one reset", d, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
